// File: pia_arb.sv
// package of constants and types, plus the vector priority arbiter
`timescale 1ns/1ns
package pia_pkg;
    localparam int NUM_SRC = 29;
    localparam int NUM_VEC = 10;

    // priority levels, higher code outranks lower; zero means nothing in service
    localparam logic [1:0] LVL_NONE = 2'h0;
    localparam logic [1:0] LVL_L    = 2'h1;
    localparam logic [1:0] LVL_H    = 2'h2;
    localparam logic [1:0] LVL_X    = 2'h3;

    // vectors below this index choose between X and L, the rest between H and L
    localparam logic [3:0] NUM_X_VEC = 4'h2;

    // vector addresses: base plus a fixed step per vector
    localparam logic [16:0] VEC_BASE = 17'h00003;
    localparam logic [16:0] VEC_STEP = 17'h00008;
    localparam logic [3:0]  VEC_SHARED_SERIAL = 4'h6;

    // source positions within the request vector
    localparam int SRC_PIN_A   = 0;
    localparam int SRC_PIN_B   = 1;
    localparam int SRC_PIN_C   = 2;
    localparam int SRC_USB_ACT = 4;
    localparam int SRC_BTMR    = 6;
    localparam int SRC_PORT0   = 24;

    // which sources share each vector
    localparam logic [NUM_SRC-1:0] VEC_SRC_MASK [NUM_VEC] = '{
        29'h0000001, 29'h0000002, 29'h000001C, 29'h0000060, 29'h0000080,
        29'h0000300, 29'h0003C00, 29'h01FC000, 29'h0E00000, 29'h1F000000};

    typedef enum logic [1:0] {PIA_RUN, PIA_HALT, PIA_HOLD, PIA_XHOLD} pia_mode_t;

    typedef struct packed {
        pia_mode_t   mode;
        logic [2:0]  in_svc;          // one bit per level L, H, X
        logic        irq_req;
        logic [3:0]  irq_index;
        logic [16:0] irq_vec_addr;
        logic [1:0]  irq_level;
        logic [1:0]  svc_lvl;         // highest level in service, registered
        logic        cpu_run_en;
        logic        periph_run_en;
        logic        base_timer_run_en;
        logic        pll_run_en;
        logic        ceramic_osc_en;
        logic        rc_osc_en;
        logic        crystal_osc_en;
    } pia_state_t;

    localparam pia_state_t PIA_ST_RST = '{
        mode: PIA_RUN, in_svc: 3'h0, irq_req: 1'b0, irq_index: 4'h0,
        irq_vec_addr: 17'h00000, irq_level: 2'h0, svc_lvl: 2'h0, cpu_run_en: 1'b1,
        periph_run_en: 1'b1, base_timer_run_en: 1'b1, pll_run_en: 1'b1,
        ceramic_osc_en: 1'b1, rc_osc_en: 1'b1, crystal_osc_en: 1'b1};

    // level of a vector from its upper/lower selection
    function automatic logic [1:0] vec_level(input logic [3:0] idx, input logic upper);
        if (!upper) begin
            return LVL_L;
        end
        return (idx < NUM_X_VEC) ? LVL_X : LVL_H;
    endfunction

    // highest level currently in service
    function automatic logic [1:0] svc_level(input logic [2:0] in_svc);
        if (in_svc[2]) begin
            return LVL_X;
        end
        if (in_svc[1]) begin
            return LVL_H;
        end
        return in_svc[0] ? LVL_L : LVL_NONE;
    endfunction

    // drop the innermost (highest) level in service
    function automatic logic [2:0] svc_pop(input logic [2:0] in_svc);
        if (in_svc[2]) begin
            return {1'b0, in_svc[1:0]};
        end
        if (in_svc[1]) begin
            return {2'h0, in_svc[0]};
        end
        return 3'h0;
    endfunction
endpackage

module pia_arb
    import pia_pkg::*;
(
    input  wire logic [NUM_VEC-1:0]   vec_pend,
    input  wire logic [2*NUM_VEC-1:0] vec_lvl,
    input  wire logic [1:0]           cur_lvl,
    output logic                      grant_valid,
    output logic [3:0]                grant_idx,
    output logic [1:0]                grant_lvl
);
    // descending scan with >= lets the smaller vector win a tie
    always_comb begin
        grant_valid = 1'b0;
        grant_idx   = 4'h0;
        grant_lvl   = LVL_NONE;
        for (int i = NUM_VEC - 1; i >= 0; i--) begin
            if (vec_pend[i] && (vec_lvl[2*i +: 2] > cur_lvl)
                    && (vec_lvl[2*i +: 2] >= grant_lvl)) begin
                grant_valid = 1'b1;
                grant_idx   = 4'(i);
                grant_lvl   = vec_lvl[2*i +: 2];
            end
        end
    end
endmodule // pia_arb

// File: pia_ctrl.sv
// interrupt arbitration with level nesting and standby mode control
`timescale 1ns/1ns
// How it works
// - three levels, X above H above L
// - refuse requests not above level in service
// - highest level wins, then smallest vector
// - 29 sources folded onto 10 vectors
// - serial, usb reset/suspend, uart rx share 00033H
// - halt stops cpu, peripherals and oscillators run
// - halt ends on reset or interrupt
// - hold stops cpu, peripherals, all oscillators
// - hold wakes on reset pin or pins
// - hold also wakes on port0, usb active
// - crystal hold keeps only base timer running
// - crystal hold stops pll, ceramic, rc; crystal kept
// - crystal hold adds base timer wake
module pia_ctrl
    import pia_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               ce,
    input  wire logic [NUM_SRC-1:0] irq_src,
    input  wire logic [NUM_VEC-1:0] vec_upper_sel,
    input  wire logic               int_take,
    input  wire logic               int_return,
    input  wire logic               halt_cmd,
    input  wire logic               hold_cmd,
    input  wire logic               xhold_cmd,
    input  wire logic               reset_pin_n,
    input  wire logic               ext_irq_pin_a,
    input  wire logic               ext_irq_pin_b,
    input  wire logic               ext_irq_pin_c,
    input  wire logic [2:0]         pin_active_high,
    input  wire logic               pll_cfg_on,
    input  wire logic               ceramic_oscillator_cfg_on,
    input  wire logic               internal_resistor_cap_oscillator_cfg_on,
    input  wire logic               crystal_cfg_on,
    output logic                    irq_req,
    output logic [3:0]              irq_index,
    output logic [16:0]             irq_vec_addr,
    output logic [1:0]              irq_level,
    output logic [1:0]              svc_level_out,
    output logic [1:0]              standby_mode,
    output logic                    cpu_run_en,
    output logic                    periph_run_en,
    output logic                    base_timer_run_en,
    output logic                    pll_run_en,
    output logic                    ceramic_oscillator_en,
    output logic                    internal_resistor_cap_oscillator_en,
    output logic                    crystal_osc_en
);
    pia_state_t st;
    pia_state_t next_st;

    logic [NUM_VEC-1:0]   vec_pend;
    logic [2*NUM_VEC-1:0] vec_lvl;
    logic                 grant_valid;
    logic [3:0]           grant_idx;
    logic [1:0]           grant_lvl;
    logic [1:0]           cur_lvl;
    logic                 pin_wake;
    logic                 hold_wake;
    logic                 xhold_wake;

    // fold sources onto vectors and attach each vector's level
    always_comb begin
        for (int v = 0; v < NUM_VEC; v++) begin
            vec_pend[v]       = |(irq_src & VEC_SRC_MASK[v]);
            vec_lvl[2*v +: 2] = vec_level(4'(v), vec_upper_sel[v]);
        end
    end

    assign cur_lvl = svc_level(st.in_svc);

    pia_arb u_arb (
        .vec_pend    (vec_pend),
        .vec_lvl     (vec_lvl),
        .cur_lvl     (cur_lvl),
        .grant_valid (grant_valid),
        .grant_idx   (grant_idx),
        .grant_lvl   (grant_lvl)
    );

    // wake causes: raw pins work with every clock stopped
    assign pin_wake   = |({ext_irq_pin_c, ext_irq_pin_b, ext_irq_pin_a} ~^ pin_active_high);
    assign hold_wake  = !reset_pin_n || pin_wake || irq_src[SRC_PORT0]
                        || irq_src[SRC_USB_ACT];
    assign xhold_wake = hold_wake || irq_src[SRC_BTMR];

    // next state: arbitration, nesting, standby modes
    always_comb begin
        next_st = st;
        // a take consumes the offered request, so hold off one cycle
        next_st.irq_req      = grant_valid && !int_take && st.mode != PIA_HOLD
                               && st.mode != PIA_XHOLD;
        next_st.irq_index    = grant_idx;
        next_st.irq_vec_addr = VEC_BASE + VEC_STEP * {13'h0, grant_idx};
        next_st.irq_level    = grant_lvl;
        if (int_take && st.irq_req) begin
            next_st.in_svc[st.irq_level - 2'h1] = 1'b1;
        end else if (int_return) begin
            next_st.in_svc = svc_pop(st.in_svc);
        end
        next_st.svc_lvl = svc_level(next_st.in_svc);
        unique case (st.mode)
            PIA_RUN: begin
                if (halt_cmd) begin
                    next_st.mode = PIA_HALT;
                end else if (hold_cmd) begin
                    next_st.mode = PIA_HOLD;
                end else if (xhold_cmd) begin
                    next_st.mode = PIA_XHOLD;
                end
            end
            PIA_HALT: begin
                if (!reset_pin_n || grant_valid) begin
                    next_st.mode = PIA_RUN;
                end
            end
            PIA_HOLD: begin
                if (hold_wake) begin
                    next_st.mode = PIA_RUN;
                end
            end
            PIA_XHOLD: begin
                if (xhold_wake) begin
                    next_st.mode = PIA_RUN;
                end
            end
        endcase
        // clock and run enables follow the mode being entered
        unique case (next_st.mode)
            PIA_RUN, PIA_HALT: begin
                next_st.cpu_run_en        = next_st.mode == PIA_RUN;
                next_st.periph_run_en     = 1'b1;
                next_st.base_timer_run_en = 1'b1;
                next_st.pll_run_en        = pll_cfg_on;
                next_st.ceramic_osc_en    = ceramic_oscillator_cfg_on;
                next_st.rc_osc_en         = internal_resistor_cap_oscillator_cfg_on;
                next_st.crystal_osc_en    = crystal_cfg_on;
            end
            PIA_HOLD: begin
                next_st.cpu_run_en        = 1'b0;
                next_st.periph_run_en     = 1'b0;
                next_st.base_timer_run_en = 1'b0;
                next_st.pll_run_en        = 1'b0;
                next_st.ceramic_osc_en    = 1'b0;
                next_st.rc_osc_en         = 1'b0;
                next_st.crystal_osc_en    = 1'b0;
            end
            PIA_XHOLD: begin
                next_st.cpu_run_en        = 1'b0;
                next_st.periph_run_en     = 1'b0;
                next_st.base_timer_run_en = 1'b1;
                next_st.pll_run_en        = 1'b0;
                next_st.ceramic_osc_en    = 1'b0;
                next_st.rc_osc_en         = 1'b0;
                next_st.crystal_osc_en    = st.crystal_osc_en;
            end
        endcase
    end

    // state register, frozen while ce is low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= PIA_ST_RST;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // outputs straight from the state flops
    assign irq_req                             = st.irq_req;
    assign irq_index                           = st.irq_index;
    assign irq_vec_addr                        = st.irq_vec_addr;
    assign irq_level                           = st.irq_level;
    assign svc_level_out                       = st.svc_lvl;
    assign standby_mode                        = st.mode;
    assign cpu_run_en                          = st.cpu_run_en;
    assign periph_run_en                       = st.periph_run_en;
    assign base_timer_run_en                   = st.base_timer_run_en;
    assign pll_run_en                          = st.pll_run_en;
    assign ceramic_oscillator_en               = st.ceramic_osc_en;
    assign internal_resistor_cap_oscillator_en = st.rc_osc_en;
    assign crystal_osc_en                      = st.crystal_osc_en;

    // checks
    property p_lvl_order;
        @(posedge clk) disable iff (rst)
        ce && grant_valid && vec_pend[0] && vec_upper_sel[0] && cur_lvl != LVL_X
            |-> grant_lvl == LVL_X;
    endproperty
    a_lvl_order: assert property (p_lvl_order) else $error("X level not winning");

    property p_above_svc;
        @(posedge clk) disable iff (rst)
        irq_req |-> irq_level > cur_lvl;
    endproperty
    a_above_svc: assert property (p_above_svc) else $error("request not above level");

    property p_small_vec;
        @(posedge clk) disable iff (rst)
        ce && grant_valid && grant_idx != 4'h0 && vec_pend[0]
            && vec_level(4'h0, vec_upper_sel[0]) > cur_lvl
            |-> vec_level(4'h0, vec_upper_sel[0]) < grant_lvl;
    endproperty
    a_small_vec: assert property (p_small_vec) else $error("vector 0 lost tie");

    property p_shared;
        @(posedge clk) disable iff (rst)
        $past(ce) && irq_req && irq_index == VEC_SHARED_SERIAL
            |-> $past(|irq_src[13:10]) && irq_vec_addr == 17'h00033;
    endproperty
    a_shared: assert property (p_shared) else $error("shared vector mismatch");

    sequence s_halt_enter;
        ce && st.mode == PIA_RUN && halt_cmd;
    endsequence
    property p_halt;
        @(posedge clk) disable iff (rst)
        s_halt_enter |=> !cpu_run_en && periph_run_en && pll_run_en == $past(pll_cfg_on);
    endproperty
    a_halt: assert property (p_halt) else $error("halt enables wrong");

    property p_halt_exit;
        @(posedge clk) disable iff (rst)
        ce && st.mode == PIA_HALT && grant_valid |=> st.mode == PIA_RUN && cpu_run_en;
    endproperty
    a_halt_exit: assert property (p_halt_exit) else $error("halt not left");

    property p_hold_off;
        @(posedge clk) disable iff (rst)
        st.mode == PIA_HOLD |-> !cpu_run_en && !periph_run_en && !pll_run_en
            && !ceramic_oscillator_en && !internal_resistor_cap_oscillator_en
            && !crystal_osc_en;
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("hold left a clock on");

    property p_hold_wake;
        @(posedge clk) disable iff (rst)
        ce && st.mode == PIA_HOLD && (pin_wake || irq_src[SRC_PORT0]) |=> st.mode == PIA_RUN;
    endproperty
    a_hold_wake: assert property (p_hold_wake) else $error("hold not released");

    sequence s_in_xhold;
        st.mode == PIA_XHOLD ##1 st.mode == PIA_XHOLD;
    endsequence
    property p_xhold_keep;
        @(posedge clk) disable iff (rst)
        s_in_xhold |-> $stable(crystal_osc_en) && base_timer_run_en && !periph_run_en
            && !pll_run_en && !ceramic_oscillator_en;
    endproperty
    a_xhold_keep: assert property (p_xhold_keep) else $error("crystal hold state wrong");

    property p_xhold_wake;
        @(posedge clk) disable iff (rst)
        ce && st.mode == PIA_XHOLD && irq_src[SRC_BTMR] |=> st.mode == PIA_RUN;
    endproperty
    a_xhold_wake: assert property (p_xhold_wake) else $error("base timer wake lost");

    property p_restore;
        @(posedge clk) disable iff (rst)
        ce && int_return && !(int_take && irq_req) && st.in_svc == 3'h3
            |=> cur_lvl == LVL_L;
    endproperty
    a_restore: assert property (p_restore) else $error("level not restored");
endmodule // pia_ctrl

// File: pia_cpu_model.sv
// cpu side model: accepts offered interrupts and returns on command
`timescale 1ns/1ns
module pia_cpu_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic irq_req,
    input  wire logic auto_take,
    input  wire logic slow,
    input  wire logic ret_go,
    output logic      int_take,
    output logic      int_return
);
    logic [1:0] seen;

    // one take per standing offer; slow waits for three cycles of offer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seen       <= 2'h0;
            int_take   <= 1'b0;
            int_return <= 1'b0;
        end else begin
            seen       <= (irq_req && !int_take) ? ((seen == 2'h3) ? seen : seen + 2'h1) : 2'h0;
            int_take   <= auto_take && irq_req && !int_take && (!slow || seen == 2'h3);
            int_return <= ret_go && !int_return;
        end
    end
endmodule // pia_cpu_model

// File: tb.sv
// self-checking bench for the interrupt and standby controller
`timescale 1ns/1ns
module tb;
    import pia_pkg::*;
    logic clk, rst, ce, int_take, int_return, halt_cmd, hold_cmd, xhold_cmd, reset_pin_n;
    logic pin_a, pin_b, pin_c, pll_on, cer_on, rc_on, xtal_on, auto_take, slow, ret_go;
    logic [NUM_SRC-1:0] irq_src;
    logic [NUM_VEC-1:0] upper;
    logic [2:0]  pin_act;
    logic        irq_req, cpu_en, per_en, bt_en, pll_en, cer_en, rc_en, xt_en;
    logic [3:0]  irq_index;
    logic [16:0] irq_vec_addr;
    logic [1:0]  irq_level, svc_lvl, mode;
    int          err_total, check_count, cyc;

    pia_ctrl u_pia_ctrl (.clk(clk), .rst(rst), .ce(ce), .irq_src(irq_src),
        .vec_upper_sel(upper), .int_take(int_take), .int_return(int_return),
        .halt_cmd(halt_cmd), .hold_cmd(hold_cmd), .xhold_cmd(xhold_cmd),
        .reset_pin_n(reset_pin_n), .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b),
        .ext_irq_pin_c(pin_c), .pin_active_high(pin_act), .pll_cfg_on(pll_on),
        .ceramic_oscillator_cfg_on(cer_on), .internal_resistor_cap_oscillator_cfg_on(rc_on),
        .crystal_cfg_on(xtal_on), .irq_req(irq_req), .irq_index(irq_index),
        .irq_vec_addr(irq_vec_addr), .irq_level(irq_level), .svc_level_out(svc_lvl),
        .standby_mode(mode), .cpu_run_en(cpu_en), .periph_run_en(per_en),
        .base_timer_run_en(bt_en), .pll_run_en(pll_en), .ceramic_oscillator_en(cer_en),
        .internal_resistor_cap_oscillator_en(rc_en), .crystal_osc_en(xt_en));
    pia_cpu_model u_pia_cpu_model (.clk(clk), .rst(rst), .irq_req(irq_req),
        .auto_take(auto_take), .slow(slow), .ret_go(ret_go), .int_take(int_take),
        .int_return(int_return));

    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            err_total++;
            print_verdict();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic [6:0] run_en();
        return {3'b111, pll_on, cer_on, rc_on, xtal_on};
    endfunction
    function automatic logic [6:0] en_now();
        return {cpu_en, per_en, bt_en, pll_en, cer_en, rc_en, xt_en};
    endfunction

    // level beats address, then smallest vector; every source lands on its vector
    task automatic t_arb();
        int v;
        irq_src = 29'h9;
        upper = 10'h004;
        step(2);
        check("win_h_idx", irq_index, 2);
        check("win_h_lvl", irq_level, LVL_H);
        upper = 10'h005;
        step(2);
        check("win_x_addr", irq_vec_addr, 32'h3);
        upper = 10'h000;
        step(2);
        check("tie_idx", irq_index, 0);
        for (int i = 0; i < 29; i++) begin
            irq_src = 29'h1 << i;
            v = (i >= 1) + (i >= 2) + (i >= 5) + (i >= 7) + (i >= 8) + (i >= 10)
                + (i >= 14) + (i >= 21) + (i >= 24);
            step(2);
            check("src_idx", irq_index, v);
            check("src_addr", irq_vec_addr, 3 + 8 * v);
        end
        irq_src = '0;
        step(2);
    endtask

    // nested service and unwinding on return
    task automatic t_nest();
        auto_take = 1'b1;
        irq_src = 29'h1;
        step(6);
        check("svc_l", svc_lvl, LVL_L);
        irq_src = 29'h9;
        step(3);
        check("same_lvl_ref", irq_req, 0);
        upper = 10'h004;
        step(6);
        check("svc_h", svc_lvl, LVL_H);
        slow = 1'b1;
        upper = 10'h006;
        irq_src = 29'hB;
        step(9);
        check("svc_x", svc_lvl, LVL_X);
        auto_take = 1'b0;
        irq_src = '0;
        for (int k = 2; k >= 0; k--) begin
            ret_go = 1'b1;
            step(1);
            ret_go = 1'b0;
            step(3);
            check("svc_ret", svc_lvl, k);
        end
        slow = 1'b0;
        upper = '0;
    endtask

    // halt keeps peripherals and oscillators; request or reset pin ends it
    task automatic t_halt();
        for (int k = 0; k < 2; k++) begin
            {pll_on, cer_on, rc_on} = k[0] ? 3'b010 : 3'b101;
            halt_cmd = 1'b1;
            step(1);
            halt_cmd = 1'b0;
            check("halt_mode", mode, 1);
            check("halt_en", en_now(), run_en() & 7'h3F);
            step(3);
            check("halt_stay", mode, 1);
            if (k == 0) irq_src = 29'h200000;
            else reset_pin_n = 1'b0;
            step(2);
            check("halt_wake", mode, 0);
            irq_src = '0;
            reset_pin_n = 1'b1;
            step(2);
        end
    endtask

    task automatic set_cause(input int c, input logic on);
        case (c)
            0: reset_pin_n = !on;
            1: pin_a = on;
            2: pin_b = !on;
            3: pin_c = on;
            4: irq_src[24] = on;
            5: irq_src[4] = on;
            default: irq_src[6] = on;
        endcase
    endtask

    // hold and crystal hold: stopped units, crystal retained in crystal hold only, each wake cause
    task automatic t_hold(input logic xh);
        for (int c = 0; c < (xh ? 7 : 6); c++) begin
            xtal_on = c[0];
            step(2);
            if (xh) xhold_cmd = 1'b1;
            else hold_cmd = 1'b1;
            step(1);
            xhold_cmd = 1'b0;
            hold_cmd = 1'b0;
            xtal_on = !c[0];
            check("hold_mode", mode, xh ? 3 : 2);
            check("hold_en", en_now(), xh ? {6'h08, c[0]} : 7'h00);
            if (!xh) irq_src[6] = 1'b1;
            step(3);
            check("hold_stay", mode, xh ? 3 : 2);
            check("xhold_bt", bt_en, xh);
            check("xhold_xt", xt_en, xh ? c[0] : 1'b0);
            irq_src[6] = 1'b0;
            set_cause(c, 1'b1);
            step(2);
            check("hold_wake", mode, 0);
            check("wake_en", en_now(), run_en());
            set_cause(c, 1'b0);
            step(2);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // reset, then the scenarios in turn
    initial begin
        err_total = 0;
        check_count = 0;
        cyc = 0;
        {rst, ce, irq_src, upper, halt_cmd, hold_cmd, xhold_cmd} = {2'b11, 42'h0};
        {reset_pin_n, pin_a, pin_b, pin_c, pin_act} = {4'b1010, 3'b101};
        {pll_on, cer_on, rc_on, xtal_on, auto_take, slow, ret_go} = 7'b1011000;
        step(2);
        check("rst_en", en_now(), 7'h7F);
        check("rst_req", irq_req, 0);
        rst = 1'b0;
        step(2);
        check("run_en", en_now(), run_en());
        t_arb();
        t_nest();
        t_halt();
        t_hold(1'b0);
        t_hold(1'b1);
        print_verdict();
    end
endmodule // tb
